/* File: src/eisp_defines.svh */
// Purpose: Named offsets, field positions, reset values and codes of the external interrupt sense block.
// Assumes: Register indices are byte addresses divided by four on the APB.
// Notes: Included by bare name from every design file except the package.
`ifndef EISP_DEFINES_SVH
`define EISP_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EISP_IDX_PRIO0 6'h25
`define EISP_IDX_PRIO1 6'h26
`define EISP_IDX_PRIO2 6'h27
`define EISP_IDX_PRIO3 6'h28
`define EISP_IDX_SENSE 6'h29
`define EISP_IDX_TOP 6'h2a
`define EISP_IDX_STAT 6'h2b
`define EISP_IDX_MASK 6'h2c

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define EISP_PRIO_RST 8'hff
`define EISP_PRIO3_RO 8'hf0
`define EISP_PRIO_RW 8'h00
`define EISP_CTRL_RST 8'h00
`define EISP_EVT_RST 5'h00
`define EISP_LEVEL0 2'h2

// ----------------------------------------------------------------
// Field positions and sensitivity codes
// ----------------------------------------------------------------
`define EISP_TOP_EN_BIT 0
`define EISP_TOP_SEL_BIT 1
`define EISP_TOP_EVT_BIT 4
`define EISP_SENSE_LOWFALL 2'h0
`define EISP_SENSE_RISE 2'h1
`define EISP_SENSE_FALL 2'h2
`define EISP_SENSE_BOTH 2'h3

`endif

/* File: src/eisp_pkg.sv */
// Purpose: Types shared by the external interrupt sense block.
// Assumes: Nothing beyond the defines header.
// Notes: Fields are packed most significant source first.
package eisp_pkg;

	// Sensitivity control register layout, source 3 in the top bits.
	typedef struct packed {
		logic [1:0] sense_sel_src3;
		logic [1:0] sense_sel_src2;
		logic [1:0] sense_sel_src1;
		logic [1:0] sense_sel_src0;
	} eisp_sense_t;

	// Top-level interrupt control bits.
	typedef struct packed {
		logic top_irq_edge_sel;
		logic top_irq_enable;
	} eisp_top_t;

endpackage

/* File: src/eisp_edge_detect.sv */
// Purpose: Synchronise one interrupt pin and flag the selected edge or level.
// Assumes: Pins idle high, as with a pull-up input.
// Notes: Event output is registered and lags the pin by three clocks.
`timescale 1ns/1ps
`default_nettype none
`include "eisp_defines.svh"

module eisp_edge_detect (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and selection
	input wire logic pin,
	input wire logic [1:0] mode,
	// Detection
	output logic event_pulse
);

	logic sync1, sync2, prev;
	logic next_event;
	logic rise, fall;

	// ----------------------------------------------------------------
	// Detection
	// ----------------------------------------------------------------
	// Synchroniser resets high so an idle-high pin gives no false low level.
	always_comb begin
		rise = sync2 & ~prev;
		fall = ~sync2 & prev;
		case (mode)
			`EISP_SENSE_LOWFALL: next_event = ~sync2;
			`EISP_SENSE_RISE: next_event = rise;
			`EISP_SENSE_FALL: next_event = fall;
			`EISP_SENSE_BOTH: next_event = rise | fall;
			default: next_event = 1'b0;
		endcase
	end

	// Registers only; sync1 feeds sync2 alone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			prev <= 1'b1;
			event_pulse <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			prev <= sync2;
			event_pulse <= next_event;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_rise_flags: assert property (mode == `EISP_SENSE_RISE && $rose(sync2) |=> event_pulse)
		else $error("rising edge not flagged");
	chk_fall_only: assert property (mode == `EISP_SENSE_FALL && !(prev && !sync2) |=> !event_pulse)
		else $error("event without falling edge");

endmodule
`default_nettype wire

/* File: src/eisp_prio_reg.sv */
// Purpose: One software priority register of four two-bit pairs.
// Assumes: Writes are qualified by the bus slave.
// Notes: Read-only bits always read as one.
`timescale 1ns/1ps
`default_nettype none
`include "eisp_defines.svh"

module eisp_prio_reg #(
	parameter logic [7:0] RO_MASK = `EISP_PRIO_RW
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// Stored value
	output logic [7:0] q
);

	logic [7:0] next_q;

	// A pair written with the level-0 pattern keeps its old value.
	function automatic logic [7:0] eisp_filter(input logic [7:0] old_v, input logic [7:0] new_v);
		logic [7:0] r;
		r = new_v;
		for (int i = 0; i < 4; i++) begin
			if (new_v[2*i +: 2] == `EISP_LEVEL0) begin
				r[2*i +: 2] = old_v[2*i +: 2];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next value
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		if (wr_en) begin
			next_q = eisp_filter(q, wdata) | RO_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= `EISP_PRIO_RST;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_level0_keep: assert property (wr_en && wdata[1:0] == `EISP_LEVEL0 |=> q[1:0] == $past(q[1:0]))
		else $error("level 0 pattern was stored");
	chk_ro_ones: assert property ((q & RO_MASK) == RO_MASK)
		else $error("read-only priority bits not one");

endmodule
`default_nettype wire

/* File: src/eisp_top.sv */
// Purpose: External interrupt sensitivity, top-level interrupt control and priority register map on APB.
// Assumes: Core supplies its two interrupt mask bits and acknowledges serviced requests.
// Notes: One wait state on every APB access; registers sit at four times their index.
//
// Summary of operation
// - Four external sources each have their own sensitivity setting that affects no other source.
// - The sensitivity register holds source 3 in bits 7:6, source 2 in 5:4, source 1 in 3:2, source 0 in 1:0.
// - Codes select 00 falling edge and low level, 01 rising only, 10 falling only, 11 both edges.
// - Sensitivity writes take effect only while both core mask bits are one.
// - Writing a different value into a source's field clears that source's pending request.
// - The top-level edge select bit 1 chooses falling edge at 0 and rising edge at 1.
// - The edge select bit changes only while the top-level enable is clear.
// - Bit 0 enables the top-level interrupt pin and is freely writable.
// - Clearing the enable produces one parasitic top-level request.
// - Priority registers sit at 25h to 28h, sensitivity at 29h, top control at 2Ah, both controls reset to zero.
// - Priority pairs map to the vectors in fixed positions across the four registers.
// - Priority registers reset to all ones and the upper nibble of the fourth reads one.
// - A level-0 pattern written into a priority pair is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "eisp_defines.svh"

module eisp_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt pins
	input wire logic [3:0] ext_src,
	input wire logic top_level_irq,
	// Core side
	input wire logic irq_mask_hi,
	input wire logic irq_mask_lo,
	input wire logic [3:0] ext_ack,
	input wire logic top_ack,
	output logic [3:0] ext_pending,
	output logic top_irq_req,
	output logic [31:0] vector_priority_regs,
	output logic irq
);

	eisp_pkg::eisp_sense_t ext_irq_sense_ctrl, next_sense;
	eisp_pkg::eisp_top_t top_irq_ctrl, next_top;
	logic [3:0] next_pending;
	logic next_top_req;
	logic [4:0] irq_status, next_status, irq_mask, next_mask;
	logic next_irq;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [5:0] idx;
	logic acc, wr, level3, top_clear_parasitic;
	logic [3:0] ext_evt, sense_chg, prio_wr;
	logic top_det, top_evt;
	logic [7:0] sense_word;
	logic [4:0] events;

	// Register hit on a word-aligned address.
	function automatic logic eisp_hit(input logic [7:0] a, input logic [5:0] index);
		return (a[1:0] == 2'h0) && (a[7:2] == index);
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign idx = paddr[7:2];
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign level3 = irq_mask_hi & irq_mask_lo;
	assign sense_word = ext_irq_sense_ctrl;

	// ----------------------------------------------------------------
	// Pin detection
	// ----------------------------------------------------------------
	// One detector per source, each fed only its own field.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_src
			eisp_edge_detect u_det (
				.pclk(pclk),
				.presetn(presetn),
				.pin(ext_src[g]),
				.mode(sense_word[2*g +: 2]),
				.event_pulse(ext_evt[g])
			);
			assign sense_chg[g] = wr && eisp_hit(paddr, `EISP_IDX_SENSE) && level3 &&
				(pwdata[2*g +: 2] != sense_word[2*g +: 2]);
		end
	endgenerate

	// Top-level pin uses only the two pure edge codes.
	eisp_edge_detect u_top_det (
		.pclk(pclk),
		.presetn(presetn),
		.pin(top_level_irq),
		.mode(top_irq_ctrl.top_irq_edge_sel ? `EISP_SENSE_RISE : `EISP_SENSE_FALL),
		.event_pulse(top_det)
	);

	// ----------------------------------------------------------------
	// Priority registers
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < 4; g++) begin : gen_prio
			assign prio_wr[g] = wr && eisp_hit(paddr, `EISP_IDX_PRIO0 + 6'(g));
			eisp_prio_reg #(
				.RO_MASK((g == 3) ? `EISP_PRIO3_RO : `EISP_PRIO_RW)
			) u_prio (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(prio_wr[g]),
				.wdata(pwdata[7:0]),
				.q(vector_priority_regs[8*g +: 8])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Control, pending and status next values
	// ----------------------------------------------------------------
	// Set beats clear on every flag so an event landing on a clear is kept.
	always_comb begin
		next_sense = ext_irq_sense_ctrl;
		next_top = top_irq_ctrl;
		next_mask = irq_mask;
		top_clear_parasitic = 1'b0;
		if (wr && eisp_hit(paddr, `EISP_IDX_SENSE) && level3) begin
			next_sense = pwdata[7:0];
		end
		if (wr && eisp_hit(paddr, `EISP_IDX_TOP)) begin
			next_top.top_irq_enable = pwdata[`EISP_TOP_EN_BIT];
			if (!top_irq_ctrl.top_irq_enable) begin
				next_top.top_irq_edge_sel = pwdata[`EISP_TOP_SEL_BIT];
			end
			top_clear_parasitic = top_irq_ctrl.top_irq_enable & ~pwdata[`EISP_TOP_EN_BIT];
		end
		if (wr && eisp_hit(paddr, `EISP_IDX_MASK)) begin
			next_mask = pwdata[4:0];
		end
		top_evt = (top_det & top_irq_ctrl.top_irq_enable) | top_clear_parasitic;
		next_pending = ext_evt | (ext_pending & ~ext_ack & ~sense_chg);
		next_top_req = top_evt | (top_irq_req & ~top_ack);
		events = {top_evt, ext_evt};
		next_status = irq_status;
		if (wr && eisp_hit(paddr, `EISP_IDX_STAT)) begin
			next_status = irq_status & ~pwdata[4:0];
		end
		next_status = next_status | events;
		next_irq = |(next_status & next_mask);
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	// One wait state keeps prdata and pready registered outputs.
	always_comb begin
		next_pready = psel & penable & ~pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (next_pready) begin
			next_prdata = 32'h0000_0000;
			if (paddr[1:0] != 2'h0) begin
				next_pslverr = 1'b1;
			end else begin
				case (idx)
					`EISP_IDX_PRIO0: next_prdata[7:0] = vector_priority_regs[7:0];
					`EISP_IDX_PRIO1: next_prdata[7:0] = vector_priority_regs[15:8];
					`EISP_IDX_PRIO2: next_prdata[7:0] = vector_priority_regs[23:16];
					`EISP_IDX_PRIO3: next_prdata[7:0] = vector_priority_regs[31:24];
					`EISP_IDX_SENSE: next_prdata[7:0] = ext_irq_sense_ctrl;
					`EISP_IDX_TOP: next_prdata[1:0] = top_irq_ctrl;
					`EISP_IDX_STAT: next_prdata[4:0] = irq_status;
					`EISP_IDX_MASK: next_prdata[4:0] = irq_mask;
					default: next_pslverr = 1'b1;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_sense_ctrl <= `EISP_CTRL_RST;
			top_irq_ctrl <= 2'(`EISP_CTRL_RST);
			ext_pending <= 4'h0;
			top_irq_req <= 1'b0;
			irq_status <= `EISP_EVT_RST;
			irq_mask <= `EISP_EVT_RST;
			irq <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ext_irq_sense_ctrl <= next_sense;
			top_irq_ctrl <= next_top;
			ext_pending <= next_pending;
			top_irq_req <= next_top_req;
			irq_status <= next_status;
			irq_mask <= next_mask;
			irq <= next_irq;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_sense_change(int i);
		wr && eisp_hit(paddr, `EISP_IDX_SENSE) && level3 && pwdata[2*i +: 2] != sense_word[2*i +: 2] &&
			!ext_evt[i];
	endsequence

	chk_sense_locked: assert property (
		wr && eisp_hit(paddr, `EISP_IDX_SENSE) && !level3 |=> $stable(ext_irq_sense_ctrl))
		else $error("sensitivity changed while unmasked");
	chk_sense_clear: assert property (s_sense_change(0) |=> !ext_pending[0])
		else $error("pending kept after sensitivity change");
	chk_sel_locked: assert property (
		wr && eisp_hit(paddr, `EISP_IDX_TOP) && top_irq_ctrl.top_irq_enable |=>
		$stable(top_irq_ctrl.top_irq_edge_sel))
		else $error("edge select changed while enabled");
	chk_enable_write: assert property (
		wr && eisp_hit(paddr, `EISP_IDX_TOP) |=>
		top_irq_ctrl.top_irq_enable == $past(pwdata[`EISP_TOP_EN_BIT]))
		else $error("enable bit not written");
	chk_parasitic_req: assert property (
		wr && eisp_hit(paddr, `EISP_IDX_TOP) && top_irq_ctrl.top_irq_enable && !pwdata[`EISP_TOP_EN_BIT] |=>
		top_irq_req)
		else $error("no request on enable clear");
	// Any unaligned address or index outside the map must be refused in the answer cycle.
	chk_unmapped_err: assert property (
		psel && penable && !pready &&
		(paddr[1:0] != 2'h0 || idx < `EISP_IDX_PRIO0 || idx > `EISP_IDX_MASK) |=> pready && pslverr)
		else $error("unmapped address not refused");
	chk_pending_hold: assert property (ext_pending[1] && !ext_ack[1] && !sense_chg[1] |=> ext_pending[1] [*1])
		else $error("pending lost without service");
	// Status and interrupt line are registered on the same edge, one clock after the event.
	chk_irq_follow: assert property (
		ext_evt[0] && irq_mask[0] && !(wr && eisp_hit(paddr, `EISP_IDX_MASK)) |=> irq && irq_status[0])
		else $error("masked-in event gave no interrupt");

endmodule
`default_nettype wire

/* File: dv/eisp_core_model.sv */
// Purpose: Behavioural core beside the interrupt block, giving mask level and acknowledges.
// Assumes: The bench orders the level and each acknowledge.
// Notes: An acknowledge comes one clock after the order, or three when slow.
`timescale 1ns/1ps
`default_nettype none

module eisp_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Orders from the bench
	input wire logic [1:0] cc_level,
	input wire logic [4:0] ack_order,
	input wire logic slow,
	// Core side of the block
	output logic irq_mask_hi,
	output logic irq_mask_lo,
	output logic [3:0] ext_ack,
	output logic top_ack
);
	logic [4:0] s0;
	logic [4:0] s1;
	logic [4:0] s2;

	// Mask bits follow the program level; sensitivity is only changed at level 3.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{irq_mask_hi, irq_mask_lo} <= 2'h3;
			s0 <= 5'h00;
			s1 <= 5'h00;
			s2 <= 5'h00;
		end else begin
			{irq_mask_hi, irq_mask_lo} <= cc_level;
			s0 <= ack_order;
			s1 <= s0;
			s2 <= s1;
		end
	end

	// A slow core keeps requests pending longer, as a busy handler would.
	assign {top_ack, ext_ack} = slow ? s2 : s0;
endmodule

`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench of the external interrupt sense block.
// Assumes: Pins idle high; one APB master in the bench.
// Notes: Random data from a fixed seed, with corner cases among it.
`timescale 1ns/1ps
`default_nettype none
`include "eisp_defines.svh"

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, top_pin, top_irq_req, irq, hi, lo, top_ack, slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, vpr, rdata;
	logic [3:0] ext_src, ext_ack, ext_pending;
	logic [1:0] cc_level;
	logic [4:0] ack_order;
	logic [7:0] pr [4];
	logic [7:0] sv, w;
	logic [31:0] b;
	logic rerr;
	int failures, check_count, g, s;

	eisp_top i_eisp_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_src(ext_src), .top_level_irq(top_pin), .irq_mask_hi(hi), .irq_mask_lo(lo), .ext_ack(ext_ack),
		.top_ack(top_ack), .ext_pending(ext_pending), .top_irq_req(top_irq_req), .vector_priority_regs(vpr),
		.irq(irq));
	eisp_core_model i_eisp_core_model (.pclk(pclk), .presetn(presetn), .cc_level(cc_level),
		.ack_order(ack_order), .slow(slow), .irq_mask_hi(hi), .irq_mask_lo(lo), .ext_ack(ext_ack),
		.top_ack(top_ack));

	// ----------------------------------------
	// Tasks and functions
	// ----------------------------------------
	// Level-0 pairs keep the old pair; read-only bits read one.
	function logic [7:0] prio_exp(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] ro);
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			r[2*i+:2] = (wr[2*i+:2] == `EISP_LEVEL0) ? old[2*i+:2] : wr[2*i+:2];
		end
		return r | ro;
	endfunction

	task report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// The request is held until pready is seen high; a stuck slave ends the run.
	task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
	endtask

	task ack_pulse(input logic [4:0] a);
		ack_order <= a;
		@(posedge pclk);
		ack_order <= 5'h00;
		cyc(6);
	endtask

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ext_src = 4'hf;
		top_pin = 1'b1;
		cc_level = 2'h3;
		ack_order = 5'h00;
		slow = 1'b0;
		presetn = 1'b0;
		failures = 0;
		check_count = 0;
		void'($urandom(95));
		cyc(5);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 6'(`EISP_IDX_PRIO0 + i), 32'h0);
			chk("reset_reg", rdata, (i < 4) ? 32'hff : 32'h0);
		end
		chk("prio_out", vpr, 32'hffffffff);
		$display("test reset done");
		for (int i = 0; i < 4; i++) pr[i] = `EISP_PRIO_RST;
		for (int k = 0; k < 14; k++) begin
			g = (k < 2) ? 0 : $urandom_range(3);
			w = (k == 0) ? 8'hcf : ((k == 1) ? 8'h64 : 8'($urandom));
			apb(1'b1, 6'(`EISP_IDX_PRIO0 + g), {24'h0, w});
			pr[g] = prio_exp(pr[g], w, (g == 3) ? `EISP_PRIO3_RO : `EISP_PRIO_RW);
			apb(1'b0, 6'(`EISP_IDX_PRIO0 + g), 32'h0);
			chk("prio_reg", rdata, {24'h0, pr[g]});
		end
		chk("prio_out", vpr, {pr[3], pr[2], pr[1], pr[0]});
		$display("test priority done");
		sv = 8'($urandom);
		apb(1'b1, `EISP_IDX_SENSE, {24'h0, sv});
		for (int l = 0; l < 3; l++) begin
			cc_level <= 2'(l);
			cyc(2);
			apb(1'b1, `EISP_IDX_SENSE, {24'h0, ~sv});
			apb(1'b0, `EISP_IDX_SENSE, 32'h0);
			chk("sense_locked", rdata, {24'h0, sv});
		end
		cc_level <= 2'h3;
		cyc(2);
		$display("test sense lock done");
		// Each code on one random source; the others must stay quiet.
		s = $urandom_range(3);
		b = 32'h1 << s;
		for (int m = 0; m < 4; m++) begin
			sv = 8'haa;
			sv[2*s+:2] = 2'(m);
			slow <= m[0];
			apb(1'b1, `EISP_IDX_SENSE, {24'h0, sv});
			apb(1'b0, `EISP_IDX_SENSE, 32'h0);
			chk("sense_reg", rdata, {24'h0, sv});
			ext_src[s] <= 1'b0;
			cyc(6);
			chk("pend_fall", {28'h0, ext_pending}, (m != 1) ? b : 32'h0);
			ack_pulse(5'(b));
			chk("pend_low", {28'h0, ext_pending}, (m == 0) ? b : 32'h0);
			ext_src[s] <= 1'b1;
			cyc(6);
			chk("pend_rise", {28'h0, ext_pending}, (m != 2) ? b : 32'h0);
			ack_pulse(5'(b));
			chk("pend_ack", {28'h0, ext_pending}, 32'h0);
		end
		$display("test modes done");
		apb(1'b1, `EISP_IDX_SENSE, 32'haa);
		ext_src[2] <= 1'b0;
		cyc(6);
		apb(1'b1, `EISP_IDX_SENSE, 32'haa);
		cyc(2);
		chk("same_keep", {28'h0, ext_pending}, 32'h4);
		apb(1'b1, `EISP_IDX_SENSE, 32'hba);
		cyc(2);
		chk("diff_clear", {28'h0, ext_pending}, 32'h0);
		apb(1'b1, `EISP_IDX_SENSE, 32'haa);
		ext_src[2] <= 1'b1;
		cyc(6);
		$display("test change clear done");
		apb(1'b1, `EISP_IDX_TOP, 32'h1);
		top_pin <= 1'b0;
		cyc(6);
		chk("top_fall", {31'h0, top_irq_req}, 32'h1);
		ack_pulse(5'h10);
		top_pin <= 1'b1;
		cyc(6);
		chk("top_rise", {31'h0, top_irq_req}, 32'h0);
		apb(1'b1, `EISP_IDX_TOP, 32'h3);
		apb(1'b0, `EISP_IDX_TOP, 32'h0);
		chk("sel_locked", rdata, 32'h1);
		apb(1'b1, `EISP_IDX_TOP, 32'h0);
		cyc(2);
		chk("parasitic", {31'h0, top_irq_req}, 32'h1);
		ack_pulse(5'h10);
		apb(1'b1, `EISP_IDX_TOP, 32'h2);
		apb(1'b0, `EISP_IDX_TOP, 32'h0);
		chk("sel_free", rdata, 32'h2);
		// The rising edge while disabled is one the selected edge would take, so only the enable stops it.
		top_pin <= 1'b0;
		cyc(6);
		top_pin <= 1'b1;
		cyc(6);
		chk("top_off", {31'h0, top_irq_req}, 32'h0);
		apb(1'b1, `EISP_IDX_TOP, 32'h3);
		top_pin <= 1'b0;
		cyc(6);
		top_pin <= 1'b1;
		cyc(6);
		chk("top_rise", {31'h0, top_irq_req}, 32'h1);
		apb(1'b1, `EISP_IDX_TOP, 32'h0);
		ack_pulse(5'h10);
		$display("test top level done");
		apb(1'b1, `EISP_IDX_STAT, 32'h1f);
		apb(1'b1, `EISP_IDX_MASK, 32'h1);
		ext_src[1] <= 1'b0;
		cyc(6);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		apb(1'b0, `EISP_IDX_STAT, 32'h0);
		chk("status", rdata, 32'h2);
		ext_src[0] <= 1'b0;
		cyc(6);
		chk("irq_on", {31'h0, irq}, 32'h1);
		apb(1'b1, `EISP_IDX_STAT, 32'h1);
		cyc(2);
		chk("irq_clear", {31'h0, irq}, 32'h0);
		ext_src <= 4'hf;
		ack_pulse(5'h1f);
		apb(1'b0, 6'h30, 32'h0);
		chk("unmapped", {rerr, rdata[30:0]}, 32'h80000000);
		$display("test irq and map done");
		report_and_stop();
	end
endmodule

`default_nettype wire
